// File: design/port_pins.sv
`timescale 1ns/1ps

module port_pins (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic clk_en,
  input wire logic bus_access,
  input wire logic ale_high,
  input wire logic bus_write,
  input wire logic [7:0] addr_low,
  input wire logic [7:0] wr_data,
  output logic [7:0] rd_data,
  output logic rd_valid,
  input wire logic mux_latch_we,
  input wire logic [7:0] mux_latch_wdata,
  output logic [7:0] mux_pin_value,
  input wire logic quasi_latch_we,
  input wire logic [7:0] quasi_latch_wdata,
  output logic [7:0] quasi_pin_value,
  input wire logic [7:0] muxed_bus_port_i,
  output logic [7:0] muxed_bus_port_o,
  output logic [7:0] muxed_bus_port_oe,
  input wire logic [7:0] quasi_bidir_port_i,
  output logic [7:0] quasi_bidir_port_o,
  output logic [7:0] quasi_bidir_port_oe,
  output logic [7:0] quasi_weak_pullup,
  input wire logic timer_two_out,
  input wire logic timer_two_out_en,
  output logic timer_two_pin,
  output logic timer_two_trigger_pin,
  output logic serial_b_receive,
  input wire logic serial_b_transmit,
  output logic ext_irq_rise_a,
  output logic ext_irq_fall_a,
  output logic ext_irq_rise_b,
  output logic ext_irq_fall_b
);

  typedef struct packed {
    logic [7:0] mux_s1;
    logic [7:0] mux_s2;
    logic [7:0] quasi_s1;
    logic [7:0] quasi_s2;
    logic [7:0] mux_latch;
    logic [7:0] quasi_latch;
    logic [7:0] quasi_eff;
    logic [7:0][1:0] strong_cnt;
    logic [7:0] mux_o;
    logic [7:0] mux_oe;
    logic [7:0] rd_data;
    logic rd_valid;
    logic [7:0] quasi_o;
    logic [7:0] quasi_oe;
    logic [7:0] weak_pu;
  } pin_state_type;

  pin_state_type state_ff;
  pin_state_type nxt_state;
  logic [7:0] alt_out;

  irq_edge_if irq_if ();

  //////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    nxt_state = state_ff;
    alt_out = 8'hFF;
    if (timer_two_out_en) begin
      alt_out[port_pins_pkg::BIT_TIMER] = timer_two_out;
    end
    alt_out[port_pins_pkg::BIT_TXD] = serial_b_transmit;
    if (clk_en) begin
      // two-flop pin synchronisers
      nxt_state.mux_s1 = muxed_bus_port_i;
      nxt_state.mux_s2 = state_ff.mux_s1;
      nxt_state.quasi_s1 = quasi_bidir_port_i;
      nxt_state.quasi_s2 = state_ff.quasi_s1;

      // quasi-bidirectional port
      if (quasi_latch_we) begin
        nxt_state.quasi_latch = quasi_latch_wdata;
      end
      nxt_state.quasi_eff = nxt_state.quasi_latch & alt_out;
      for (int i = 0; i < 8; i++) begin
        if (nxt_state.quasi_eff[i] && !state_ff.quasi_eff[i]) begin
          nxt_state.strong_cnt[i] = port_pins_pkg::STRONG_CNT_INIT;
        end else if (state_ff.strong_cnt[i] != 2'h0) begin
          nxt_state.strong_cnt[i] = state_ff.strong_cnt[i] - 2'h1;
        end
        // strong drive when low, or during the momentary high pulse
        nxt_state.quasi_oe[i] = !nxt_state.quasi_eff[i] || (nxt_state.strong_cnt[i] != 2'h0);
      end
      nxt_state.quasi_o = nxt_state.quasi_eff;
      nxt_state.weak_pu = nxt_state.quasi_eff;

      // multiplexed port
      if (mux_latch_we) begin
        nxt_state.mux_latch = mux_latch_wdata;
      end
      nxt_state.rd_valid = 1'b0;
      if (bus_access) begin
        if (ale_high) begin
          nxt_state.mux_o = addr_low;
          nxt_state.mux_oe = 8'hFF;
        end else if (bus_write) begin
          nxt_state.mux_o = wr_data;
          nxt_state.mux_oe = 8'hFF;
        end else begin
          nxt_state.mux_o = 8'h00;
          nxt_state.mux_oe = 8'h00;
          nxt_state.rd_data = state_ff.mux_s2;
          nxt_state.rd_valid = 1'b1;
        end
      end else begin
        // open-drain i/o: a one in the latch leaves the pin floating
        nxt_state.mux_o = 8'h00;
        nxt_state.mux_oe = ~nxt_state.mux_latch;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      state_ff <= '0;
      state_ff.mux_latch <= port_pins_pkg::MUX_LATCH_RST;
      state_ff.mux_oe <= port_pins_pkg::PIN_OE_RST;
      state_ff.quasi_latch <= port_pins_pkg::QUASI_LATCH_RST;
      state_ff.quasi_eff <= port_pins_pkg::QUASI_LATCH_RST;
      state_ff.quasi_o <= port_pins_pkg::QUASI_LATCH_RST;
      state_ff.quasi_oe <= port_pins_pkg::PIN_OE_RST;
      state_ff.weak_pu <= port_pins_pkg::QUASI_PULLUP_RST;
    end else begin
      state_ff <= nxt_state;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // edge detection of the four interrupt pins
  assign irq_if.level = state_ff.quasi_s2[port_pins_pkg::BIT_IRQ_LO +: 4];

  irq_edge_detect u_irq_edge (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .clk_en(clk_en),
    .edge_io(irq_if.det)
  );

  //////////////////////////////////////////////////////////////////////////////
  // outputs
  assign rd_data = state_ff.rd_data;
  assign rd_valid = state_ff.rd_valid;
  assign mux_pin_value = state_ff.mux_s2;
  assign quasi_pin_value = state_ff.quasi_s2;
  assign muxed_bus_port_o = state_ff.mux_o;
  assign muxed_bus_port_oe = state_ff.mux_oe;
  assign quasi_bidir_port_o = state_ff.quasi_o;
  assign quasi_bidir_port_oe = state_ff.quasi_oe;
  assign quasi_weak_pullup = state_ff.weak_pu;
  assign timer_two_pin = state_ff.quasi_s2[port_pins_pkg::BIT_TIMER];
  assign timer_two_trigger_pin = state_ff.quasi_s2[port_pins_pkg::BIT_TRIG];
  assign serial_b_receive = state_ff.quasi_s2[port_pins_pkg::BIT_RXD];
  assign ext_irq_rise_a = irq_if.req[0];
  assign ext_irq_fall_a = irq_if.req[1];
  assign ext_irq_rise_b = irq_if.req[2];
  assign ext_irq_fall_b = irq_if.req[3];

  //////////////////////////////////////////////////////////////////////////////
  // checks
  sequence s_pin_released;
    $rose(quasi_bidir_port_o[2]);
  endsequence

  sequence s_strong_pulse;
    quasi_bidir_port_oe[2] ##1 quasi_bidir_port_oe[2] ##1 !quasi_bidir_port_oe[2];
  endsequence

  a_addr_phase_drive: assert property (@(posedge clk_sys) disable iff (!rstn)
    clk_en && bus_access && ale_high |=>
      muxed_bus_port_o == $past(addr_low) && muxed_bus_port_oe == 8'hFF)
    else $error("address byte not driven during strobe");

  a_data_read_float: assert property (@(posedge clk_sys) disable iff (!rstn)
    clk_en && bus_access && !ale_high && !bus_write |=> muxed_bus_port_oe == 8'h00)
    else $error("muxed port still driven in read data phase");

  a_bus_strong_write: assert property (@(posedge clk_sys) disable iff (!rstn)
    clk_en && bus_access && !ale_high && bus_write |=>
      muxed_bus_port_oe == 8'hFF && muxed_bus_port_o == $past(wr_data))
    else $error("write data not strongly driven");

  a_reset_float_mux: assert property (@(posedge clk_sys)
    $rose(rstn) |-> muxed_bus_port_oe == 8'h00)
    else $error("muxed port driven after reset");

  a_quasi_reset_high: assert property (@(posedge clk_sys)
    $rose(rstn) |-> quasi_bidir_port_oe == 8'h00 && quasi_weak_pullup == 8'hFF)
    else $error("quasi port not weakly high after reset");

  a_input_seen: assert property (@(posedge clk_sys) disable iff (!rstn)
    (clk_en ##1 clk_en ##1 1'b1) |-> quasi_pin_value == $past(quasi_bidir_port_i, 2))
    else $error("quasi pin level not visible after sync");

  a_pulldown_hold: assert property (@(posedge clk_sys) disable iff (!rstn)
    clk_en && quasi_latch_we && !quasi_latch_wdata[2] |=>
      !quasi_bidir_port_o[2] && quasi_bidir_port_oe[2])
    else $error("written zero without strong pulldown");

  a_strong_high_pulse: assert property (@(posedge clk_sys) disable iff (!rstn || !clk_en)
    s_pin_released |-> s_strong_pulse)
    else $error("momentary strong high not two cycles");

  a_txd_route: assert property (@(posedge clk_sys) disable iff (!rstn)
    clk_en && !serial_b_transmit |=> !quasi_bidir_port_o[3] && quasi_bidir_port_oe[3])
    else $error("serial transmit low not on bit three");

  a_timer_route: assert property (@(posedge clk_sys) disable iff (!rstn)
    clk_en && timer_two_out_en && !timer_two_out |=> !quasi_bidir_port_o[0])
    else $error("timer output low not on bit zero");

  a_read_capture: assert property (@(posedge clk_sys) disable iff (!rstn)
    clk_en && bus_access && !ale_high && !bus_write |=>
      rd_valid && rd_data == $past(mux_pin_value))
    else $error("read data phase did not capture pin value");

  a_latch_one_weak: assert property (@(posedge clk_sys) disable iff (!rstn)
    clk_en && quasi_latch_we && quasi_latch_wdata[5] |=>
      quasi_weak_pullup[5] && quasi_bidir_port_o[5])
    else $error("latch one without weak pullup");

  a_pulldown_kept: assert property (@(posedge clk_sys) disable iff (!rstn)
    !quasi_latch_we && !quasi_bidir_port_o[2] |=>
      !quasi_bidir_port_o[2] && quasi_bidir_port_oe[2])
    else $error("strong pulldown dropped without a write");

  a_idle_open_drain: assert property (@(posedge clk_sys) disable iff (!rstn)
    clk_en && !bus_access && mux_latch_we |=>
      muxed_bus_port_oe == ~$past(mux_latch_wdata) && muxed_bus_port_o == 8'h00)
    else $error("muxed port latch not applied as open drain");

  a_irq_pulse_one: assert property (@(posedge clk_sys) disable iff (!rstn)
    clk_en && ext_irq_rise_a |=> !ext_irq_rise_a)
    else $error("interrupt pulse longer than one cycle");

  a_freeze_state: assert property (@(posedge clk_sys) disable iff (!rstn)
    !clk_en |=> $stable(quasi_bidir_port_oe) && $stable(muxed_bus_port_oe) &&
      $stable(quasi_pin_value))
    else $error("state changed while clock enable low");

endmodule : port_pins

// File: design/port_pins_pkg.sv
package port_pins_pkg;

  localparam int unsigned PORT_W = 8;
  localparam int unsigned IRQ_LANES = 4;

  // values after reset
  localparam logic [7:0] MUX_LATCH_RST = 8'hFF;
  localparam logic [7:0] QUASI_LATCH_RST = 8'hFF;
  localparam logic [7:0] QUASI_PULLUP_RST = 8'hFF;
  localparam logic [7:0] PIN_OE_RST = 8'h00;
  localparam logic [3:0] IRQ_PREV_RST = 4'hF;

  // clock and timing
  localparam int unsigned CLK_HZ = 40_000_000;
  localparam int unsigned CLK_MHZ = CLK_HZ / 1_000_000;
  localparam int unsigned STRONG_HIGH_NS = 50;
  localparam int unsigned STRONG_HIGH_RAW = (STRONG_HIGH_NS * CLK_MHZ) / 1000;
  localparam int unsigned STRONG_HIGH_CYC = (STRONG_HIGH_RAW < 1) ? 1 : STRONG_HIGH_RAW;
  localparam logic [1:0] STRONG_CNT_INIT = 2'(STRONG_HIGH_CYC);
  localparam int unsigned MC_CLOCKS = 4;
  localparam logic [1:0] MC_LAST = 2'(MC_CLOCKS - 1);

  // alternate function bit positions of the quasi port
  localparam int unsigned BIT_TIMER = 0;
  localparam int unsigned BIT_TRIG = 1;
  localparam int unsigned BIT_RXD = 2;
  localparam int unsigned BIT_TXD = 3;
  localparam int unsigned BIT_IRQ_LO = 4;

  // irq lanes: 0 rise_a, 1 fall_a, 2 rise_b, 3 fall_b
  localparam logic [3:0] IRQ_RISE_MASK = 4'h5;

endpackage : port_pins_pkg

// File: design/irq_edge_if.sv
`timescale 1ns/1ps

interface irq_edge_if;
  logic [3:0] level;
  logic [3:0] req;

  modport core (output level, input req);
  modport det (input level, output req);
endinterface : irq_edge_if

// File: design/irq_edge_detect.sv
`timescale 1ns/1ps

module irq_edge_detect (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic clk_en,
  irq_edge_if.det edge_io
);

  typedef struct packed {
    logic [1:0] mc_cnt;
    logic primed;
    logic [3:0] prev;
    logic [3:0] req;
  } edge_state_type;

  edge_state_type state_ff;
  edge_state_type nxt_state;
  logic tick;

  assign tick = (state_ff.mc_cnt == port_pins_pkg::MC_LAST);

  //////////////////////////////////////////////////////////////////////////////
  // once per machine cycle sample, compare with previous sample
  always_comb begin
    nxt_state = state_ff;
    if (clk_en) begin
      nxt_state.req = 4'h0;
      nxt_state.mc_cnt = tick ? 2'h0 : state_ff.mc_cnt + 2'h1;
      if (tick) begin
        if (state_ff.primed) begin
          nxt_state.req = (port_pins_pkg::IRQ_RISE_MASK & edge_io.level & ~state_ff.prev) |
            (~port_pins_pkg::IRQ_RISE_MASK & ~edge_io.level & state_ff.prev);
        end
        nxt_state.prev = edge_io.level;
        nxt_state.primed = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      state_ff <= '0;
      state_ff.prev <= port_pins_pkg::IRQ_PREV_RST;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign edge_io.req = state_ff.req;

  //////////////////////////////////////////////////////////////////////////////
  a_rise_edge_flag: assert property (@(posedge clk_sys) disable iff (!rstn)
    clk_en && tick && state_ff.primed && edge_io.level[0] && !state_ff.prev[0] |=> state_ff.req[0])
    else $error("rising edge on rise_a lane not flagged");

  a_fall_edge_flag: assert property (@(posedge clk_sys) disable iff (!rstn)
    clk_en && tick && state_ff.primed && !edge_io.level[3] && state_ff.prev[3] |=> state_ff.req[3])
    else $error("falling edge on fall_b lane not flagged");

  a_sample_per_cycle: assert property (@(posedge clk_sys) disable iff (!rstn)
    clk_en && !tick |=> state_ff.req == 4'h0)
    else $error("edge flagged outside machine cycle sample");

endmodule : irq_edge_detect

// File: test/pin_partner.sv
`timescale 1ns/1ps

module pin_partner (
  input wire logic clk_sys,
  input wire logic rd_phase,
  input wire logic [7:0] mem_data,
  input wire logic [7:0] ext_low,
  input wire logic [7:0] mux_o,
  input wire logic [7:0] mux_oe,
  input wire logic [7:0] q_o,
  input wire logic [7:0] q_oe,
  input wire logic [7:0] q_pu,
  output logic [7:0] mux_pin,
  output logic [7:0] q_pin
);
  logic [7:0] float_ff = 8'hA5;

  // undriven lines wander each cycle
  always @(posedge clk_sys) float_ff <= ~float_ff;

  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (mux_oe[i]) mux_pin[i] = mux_o[i];
      else if (rd_phase) mux_pin[i] = mem_data[i];
      else mux_pin[i] = float_ff[i];
      if (q_oe[i]) q_pin[i] = q_o[i];
      else if (ext_low[i]) q_pin[i] = 1'b0;
      else q_pin[i] = q_pu[i] | float_ff[i];
    end
  end
endmodule : pin_partner

// File: test/tb_top.sv
`timescale 1ns/1ps

module tb_top;
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic bus_access = 1'b0, ale_high = 1'b0, bus_write = 1'b0, quasi_latch_we = 1'b0;
  logic timer_two_out = 1'b0, timer_two_out_en = 1'b0, serial_b_transmit = 1'b1;
  logic [7:0] addr_low = 8'h00, wr_data = 8'h00, mem_data = 8'h00, ext_low = 8'h00;
  logic [7:0] quasi_latch_wdata = 8'hFF, v;
  logic clk_en = 1'b1, mux_latch_we = 1'b0;
  logic [7:0] mux_latch_wdata = 8'hFF;
  logic [7:0] rd_data, mux_pin_value, quasi_pin_value, mux_o, mux_oe, mux_pin;
  logic [7:0] q_o, q_oe, q_pu, q_pin;
  logic rd_valid, t2, t2x, rxd;
  wire [3:0] irq;
  int err_total = 0, samples_checked = 0, seed = 32'h8EDB6F14;
  int cnt [4];

  always #12.5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) for (int k = 0; k < 4; k++) cnt[k] += irq[k];

  port_pins DUT (.clk_sys(clk_sys), .rstn(rstn), .clk_en(clk_en), .bus_access(bus_access),
    .ale_high(ale_high), .bus_write(bus_write), .addr_low(addr_low), .wr_data(wr_data),
    .rd_data(rd_data), .rd_valid(rd_valid), .mux_latch_we(mux_latch_we),
    .mux_latch_wdata(mux_latch_wdata),
    .mux_pin_value(mux_pin_value), .quasi_latch_we(quasi_latch_we),
    .quasi_latch_wdata(quasi_latch_wdata), .quasi_pin_value(quasi_pin_value),
    .muxed_bus_port_i(mux_pin), .muxed_bus_port_o(mux_o), .muxed_bus_port_oe(mux_oe),
    .quasi_bidir_port_i(q_pin), .quasi_bidir_port_o(q_o), .quasi_bidir_port_oe(q_oe),
    .quasi_weak_pullup(q_pu), .timer_two_out(timer_two_out),
    .timer_two_out_en(timer_two_out_en), .timer_two_pin(t2), .timer_two_trigger_pin(t2x),
    .serial_b_receive(rxd), .serial_b_transmit(serial_b_transmit),
    .ext_irq_rise_a(irq[0]), .ext_irq_fall_a(irq[1]), .ext_irq_rise_b(irq[2]),
    .ext_irq_fall_b(irq[3]));

  pin_partner ext (.clk_sys(clk_sys), .rd_phase(bus_access & ~ale_high & ~bus_write),
    .mem_data(mem_data), .ext_low(ext_low), .mux_o(mux_o), .mux_oe(mux_oe), .q_o(q_o),
    .q_oe(q_oe), .q_pu(q_pu), .mux_pin(mux_pin), .q_pin(q_pin));

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : print_verdict

  // two bits per lane: one pulse expected on lanes of the given direction
  function automatic logic [7:0] exp_irq(input logic rise);
    for (int k = 0; k < 4; k++) exp_irq[2*k +: 2] = (port_pins_pkg::IRQ_RISE_MASK[k] == rise);
  endfunction : exp_irq

  task automatic bus(input logic [7:0] a, input logic [7:0] d, input logic w);
    @(posedge clk_sys);
    bus_access <= 1'b1;
    ale_high <= 1'b1;
    addr_low <= a;
    @(posedge clk_sys);
    ale_high <= 1'b0;
    bus_write <= w;
    wr_data <= d;
    mem_data <= d;
    #1 chk("addr_o", a, mux_o);
    chk("addr_oe", 8'hFF, mux_oe);
    for (int i = 0; i < 5; i++) begin
      @(posedge clk_sys);
      #1 chk("data_oe", w ? 8'hFF : 8'h00, mux_oe);
    end
    if (w) chk("wr_o", d, mux_o);
    else chk("rd_data", d, rd_valid ? rd_data : ~d);
    @(posedge clk_sys);
    bus_access <= 1'b0;
    bus_write <= 1'b0;
  endtask : bus

  task automatic qwr(input logic [7:0] d);
    @(posedge clk_sys);
    quasi_latch_we <= 1'b1;
    quasi_latch_wdata <= d;
    @(posedge clk_sys);
    quasi_latch_we <= 1'b0;
  endtask : qwr

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #(25 * 20000);
    err_total++;
    print_verdict();
  end

  initial begin
    repeat (8) @(posedge clk_sys);
    #1 chk("rst_mux_oe", 8'h00, mux_oe);
    chk("rst_q_o", 8'hFF, q_o);
    chk("rst_q_pu", 8'hFF, q_pu);
    chk("rst_q_oe", 8'h00, q_oe);
    repeat (4) @(posedge clk_sys);
    rstn <= 1'b1;
    repeat (3) @(posedge clk_sys);
    #1 chk("post_mux_oe", 8'h00, mux_oe);
    bus(8'h00, 8'hFF, 1'b0);
    bus(8'hFF, 8'h00, 1'b1);
    repeat (6) begin
      v = $random(seed);
      bus(v, ~v, 1'b0);
      bus(~v, v, 1'b1);
      qwr(v);
      #1 chk("q_o_zero", v, q_o);
      chk("q_oe_zero", ~v, q_oe);
      qwr(8'hFF);
      #1 chk("q_oe_kick1", ~v, q_oe);
      @(posedge clk_sys);
      #1 chk("q_oe_kick2", ~v, q_oe);
      @(posedge clk_sys);
      #1 chk("q_oe_off", 8'h00, q_oe);
      chk("q_pu_back", 8'hFF, q_pu);
      ext_low <= v;
      repeat (3) @(posedge clk_sys);
      #1 chk("q_in", ~v, quasi_pin_value);
      chk("alt_in", {5'h00, ~v[2:0]}, {5'h00, rxd, t2x, t2});
      ext_low <= 8'h00;
    end
    $display("test bus and quasi done");
    serial_b_transmit <= 1'b0;
    timer_two_out_en <= 1'b1;
    repeat (3) @(posedge clk_sys);
    #1 chk("alt_out", 8'hF6, q_o);
    serial_b_transmit <= 1'b1;
    timer_two_out_en <= 1'b0;
    ext_low <= 8'hF0;
    repeat (12) @(posedge clk_sys);
    for (int k = 0; k < 4; k++) cnt[k] = 0;
    ext_low <= 8'h00;
    repeat (12) @(posedge clk_sys);
    #1 chk("irq_rise", exp_irq(1'b1), {cnt[3][1:0], cnt[2][1:0], cnt[1][1:0], cnt[0][1:0]});
    for (int k = 0; k < 4; k++) cnt[k] = 0;
    ext_low <= 8'hF0;
    repeat (12) @(posedge clk_sys);
    #1 chk("irq_fall", exp_irq(1'b0), {cnt[3][1:0], cnt[2][1:0], cnt[1][1:0], cnt[0][1:0]});
    $display("test alternate functions done");
    @(posedge clk_sys);
    mux_latch_we <= 1'b1;
    mux_latch_wdata <= 8'h0F;
    @(posedge clk_sys);
    mux_latch_we <= 1'b0;
    #1 chk("mux_od_oe", 8'hF0, mux_oe);
    repeat (3) @(posedge clk_sys);
    #1 chk("mux_pin_low", 8'h00, mux_pin_value & 8'hF0);
    @(posedge clk_sys);
    mux_latch_we <= 1'b1;
    mux_latch_wdata <= 8'hFF;
    @(posedge clk_sys);
    mux_latch_we <= 1'b0;
    clk_en <= 1'b0;
    qwr(8'h00);
    #1 chk("frozen_q_oe", 8'h00, q_oe);
    @(posedge clk_sys);
    clk_en <= 1'b1;
    @(posedge clk_sys);
    #1 chk("thaw_q_oe", 8'h00, q_oe);
    chk("thaw_mux_oe", 8'h00, mux_oe);
    $display("test open drain and freeze done");
    print_verdict();
  end
endmodule : tb_top
